// File: usbrb_pkg.sv
// usbrb_pkg: constants and types of the usb device hard register bank
package usbrb_pkg;

    // ----------------------------------------
    // register byte offsets inside the bank
    // ----------------------------------------
    localparam logic [7:0] OFS_ADDRESS = 8'h00;
    localparam logic [7:0] OFS_CONTROL = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_FRAME = 8'h0C;
    localparam logic [7:0] OFS_IENABLE = 8'h10;
    localparam logic [7:0] OFS_READY = 8'h14;
    localparam int OFS_W = 8;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int ADDR_W = 7;
    localparam int RUN_BIT = 31;
    localparam int MASTER_BIT = 31;
    localparam int STAT_W = 24;
    localparam int ST_BUS_RESET = 23;
    localparam int ST_SUSPEND = 22;
    localparam int ST_DETACH = 21;
    localparam int ST_EP0_RX = 20;
    localparam int ST_EP0_TX = 19;
    localparam int ST_SETUP = 18;
    localparam int ST_SOF = 17;
    localparam int ST_HIGH_SPEED = 16;
    localparam int BUF_W = 16;
    localparam int UNUSED_BUF = 8;
    localparam int SECOND_BUF_BASE = 8;
    localparam int FRAME_W = 11;
    localparam int FRAME_LSB = 3;
    localparam int MICRO_W = 3;
    localparam int MICRO_LSB = 0;
    localparam int EP_NUM = 8;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
    localparam logic RUN_RST = 1'b0;
    localparam logic [STAT_W-1:0] STAT_RST = 24'h00_0000;
    localparam logic [STAT_W:0] IE_RST = 25'h000_0000;
    localparam logic [BUF_W-1:0] READY_RST = 16'h0000;
    localparam logic [BUF_W-1:0] READY_MASK = 16'hFEFF;
    localparam logic [FRAME_W-1:0] FRAME_RST = 11'h000;
    localparam logic [MICRO_W-1:0] MICRO_RST = 3'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // ----------------------------------------
    // bus handshake states
    // ----------------------------------------
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK = 2'b10
    } usbrb_bus_state_t;

endpackage : usbrb_pkg

// File: usbrb_nak_decide.sv
// usbrb_nak_decide: selects a buffer ready bit and decides on a nak
`timescale 1ns/1ps
module usbrb_nak_decide
    import usbrb_pkg::*;
(
    // transaction from the engine
    input wire logic [2:0] txnEndpoint,
    input wire logic txnSecondBuf,
    input wire logic txnIsIn,
    // configuration
    input wire logic [EP_NUM-1:0] endpointDirectionFlag,
    input wire logic [BUF_W-1:0] bufReady,
    // decision
    output logic nakNeeded
);

    function automatic logic [3:0] bufIndex(input logic [2:0] ep, input logic second);
        // endpoint zero has one shared buffer at index 0
        if (ep == 3'h0) begin
            bufIndex = 4'h0;
        end else begin
            bufIndex = {second, ep};
        end
    endfunction : bufIndex

    logic [3:0] idx;
    logic dirMismatch;

    always_comb begin
        idx = bufIndex(txnEndpoint, txnSecondBuf);
        dirMismatch = (txnEndpoint != 3'h0) &&
            (endpointDirectionFlag[txnEndpoint] != txnIsIn);
        nakNeeded = !bufReady[idx] || dirMismatch;
    end

endmodule : usbrb_nak_decide

// File: usbrb_register_bank.sv
// usbrb_register_bank: hard register space of the usb device core
`timescale 1ns/1ps
module usbrb_register_bank
    import usbrb_pkg::*;
#(
    parameter int BUS_W = 32
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // processor memory bus
    input wire logic [31:0] busAddr,
    input wire logic [3:0] busByteLaneSelects,
    input wire logic [31:0] busWrData,
    input wire logic busReadNotWrite,
    input wire logic busSelect,
    output logic [31:0] busRdData,
    output logic busXferAck,
    // line conditions from the serial interface engine
    input wire logic usbResetActive,
    input wire logic suspendActive,
    input wire logic cableDetached,
    input wire logic highSpeed,
    // event pulses from the serial interface engine
    input wire logic ep0RxDone,
    input wire logic ep0TxDone,
    input wire logic setupRx,
    input wire logic sofRx,
    input wire logic [FRAME_W-1:0] sofFrameNum,
    input wire logic [BUF_W-1:0] bufComplete,
    // transaction lookup from the serial interface engine
    input wire logic txnValid,
    input wire logic [2:0] txnEndpoint,
    input wire logic txnSecondBuf,
    input wire logic txnIsIn,
    input wire logic [EP_NUM-1:0] endpointDirectionFlag,
    // results
    output logic [ADDR_W-1:0] deviceAddress,
    output logic engineRun,
    output logic [BUF_W-1:0] bufReady,
    output logic nakValid,
    output logic nakRequired,
    output logic interrupt
);

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    if (BUS_W != 32) begin : g_badWidth
        $error("usbrb_register_bank serves a 32 bit bus only");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        usbrb_bus_state_t busState;
        logic [ADDR_W-1:0] addr;
        logic run;
        logic [STAT_W-1:0] status;
        logic [STAT_W:0] ie;
        logic [BUF_W-1:0] ready;
        logic [FRAME_W-1:0] frame;
        logic [MICRO_W-1:0] micro;
        logic [31:0] rdData;
        logic ack;
        logic irq;
        logic nakV;
        logic nak;
    } usbrb_bank_t;

    usbrb_bank_t bank_reg;
    usbrb_bank_t bank_next;

    localparam usbrb_bank_t BANK_RST = '{
        busState: BUS_IDLE, addr: ADDR_RST, run: RUN_RST,
        status: STAT_RST, ie: IE_RST, ready: READY_RST,
        frame: FRAME_RST, micro: MICRO_RST, rdData: WORD_ZERO,
        ack: 1'b0, irq: 1'b0, nakV: 1'b0, nak: 1'b0};

    function automatic logic hit(input logic [31:0] a, input logic [OFS_W-1:0] ofs);
        hit = (a[OFS_W-1:0] == ofs);
    endfunction : hit

    // ----------------------------------------
    // nak lookup
    // ----------------------------------------
    logic nakNeeded;

    usbrb_nak_decide u_nak (
        .txnEndpoint(txnEndpoint),
        .txnSecondBuf(txnSecondBuf),
        .txnIsIn(txnIsIn),
        .endpointDirectionFlag(endpointDirectionFlag),
        .bufReady(bank_reg.ready),
        .nakNeeded(nakNeeded)
    );

    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic take;
    logic rdTake;
    logic wrTake;
    logic [STAT_W-1:0] setNow;
    logic [STAT_W-1:0] clrNow;
    logic [31:0] rdWord;
    logic [BUF_W-1:0] doneBufs;

    always_comb begin
        bank_next = bank_reg;
        take = (bank_reg.busState == BUS_IDLE) && busSelect;
        rdTake = take && busReadNotWrite;
        wrTake = take && !busReadNotWrite;
        // paused engine: activity pulses are ignored
        doneBufs = bufComplete & READY_MASK & {BUF_W{bank_reg.run}};
        setNow = STAT_RST;
        setNow[ST_BUS_RESET] = usbResetActive;
        setNow[ST_SUSPEND] = suspendActive;
        setNow[ST_DETACH] = cableDetached;
        setNow[ST_EP0_RX] = ep0RxDone && bank_reg.run;
        setNow[ST_EP0_TX] = ep0TxDone && bank_reg.run;
        setNow[ST_SETUP] = setupRx && bank_reg.run;
        setNow[ST_SOF] = sofRx && bank_reg.run;
        setNow[ST_HIGH_SPEED] = highSpeed;
        setNow[BUF_W-1:0] = doneBufs;

        rdWord = WORD_ZERO;
        if (hit(busAddr, OFS_ADDRESS)) begin
            rdWord[ADDR_W-1:0] = bank_reg.addr;
        end else if (hit(busAddr, OFS_CONTROL)) begin
            rdWord[RUN_BIT] = bank_reg.run;
        end else if (hit(busAddr, OFS_STATUS)) begin
            rdWord[STAT_W-1:0] = bank_reg.status;
        end else if (hit(busAddr, OFS_FRAME)) begin
            rdWord[FRAME_LSB +: FRAME_W] = bank_reg.frame;
            rdWord[MICRO_LSB +: MICRO_W] = bank_reg.micro;
        end else if (hit(busAddr, OFS_IENABLE)) begin
            rdWord[MASTER_BIT] = bank_reg.ie[STAT_W];
            rdWord[STAT_W-1:0] = bank_reg.ie[STAT_W-1:0];
        end else if (hit(busAddr, OFS_READY)) begin
            rdWord[BUF_W-1:0] = bank_reg.ready;
        end

        clrNow = (rdTake && hit(busAddr, OFS_STATUS)) ? bank_reg.status : STAT_RST;
        // an event in the clearing cycle survives the clear
        bank_next.status = (bank_reg.status & ~clrNow) | setNow;

        // hardware retires a completed buffer; firmware rearms it
        bank_next.ready = bank_reg.ready & ~doneBufs;

        // frame from token, microframe counts extras
        if (sofRx && bank_reg.run) begin
            bank_next.frame = sofFrameNum;
            if (highSpeed && sofFrameNum == bank_reg.frame) begin
                bank_next.micro = bank_reg.micro + 3'h1;
            end else begin
                bank_next.micro = MICRO_RST;
            end
        end

        if (wrTake) begin
            if (hit(busAddr, OFS_ADDRESS)) begin
                bank_next.addr = busWrData[ADDR_W-1:0];
            end
            if (hit(busAddr, OFS_CONTROL)) begin
                bank_next.run = busWrData[RUN_BIT];
            end
            if (hit(busAddr, OFS_IENABLE)) begin
                bank_next.ie = {busWrData[MASTER_BIT], busWrData[STAT_W-1:0]};
            end
            if (hit(busAddr, OFS_READY)) begin
                bank_next.ready = busWrData[BUF_W-1:0] & READY_MASK;
            end
        end

        case (bank_reg.busState)
            BUS_IDLE: begin
                bank_next.ack = take;
                if (take) begin
                    bank_next.busState = BUS_ACK;
                    bank_next.rdData = busReadNotWrite ? rdWord : WORD_ZERO;
                end
            end
            BUS_ACK: begin
                bank_next.ack = 1'b0;
                bank_next.busState = BUS_IDLE;
            end
            default: begin
                bank_next.ack = 1'b0;
                bank_next.busState = BUS_IDLE;
            end
        endcase

        // drops once no enabled flag stays
        bank_next.irq = bank_next.ie[STAT_W] &&
            |(bank_next.status & bank_next.ie[STAT_W-1:0]);

        bank_next.nakV = txnValid && bank_reg.run;
        bank_next.nak = txnValid && bank_reg.run && nakNeeded;
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            bank_reg <= BANK_RST;
        end else begin
            bank_reg <= bank_next;
        end
    end

    assign busRdData = bank_reg.rdData;
    assign busXferAck = bank_reg.ack;
    assign deviceAddress = bank_reg.addr;
    assign engineRun = bank_reg.run;
    assign bufReady = bank_reg.ready;
    assign nakValid = bank_reg.nakV;
    assign nakRequired = bank_reg.nak;
    assign interrupt = bank_reg.irq;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    logic wrAddrHit;
    logic stRdHit;
    assign wrAddrHit = wrTake && hit(busAddr, OFS_ADDRESS);
    assign stRdHit = rdTake && hit(busAddr, OFS_STATUS);

    sequence busTakeS;
        bank_reg.busState == BUS_IDLE && busSelect;
    endsequence

    sequence ackPulseS;
        busXferAck ##1 !busXferAck;
    endsequence

    addr_write_a: assert property (
        @(posedge mclk) disable iff (rst)
        wrAddrHit |=> deviceAddress == $past(busWrData[ADDR_W-1:0]))
        else $error("address write not stored");

    addr_hold_a: assert property (
        @(posedge mclk) disable iff (rst)
        !wrAddrHit |=> $stable(deviceAddress))
        else $error("address changed without write");

    // a flag left over from before the pause may stand; only a new rise is wrong
    pause_quiet_a: assert property (
        @(posedge mclk) disable iff (rst)
        !engineRun && (txnValid || sofRx || ep0RxDone) |=> !nakValid &&
            !$rose(bank_reg.status[ST_SOF]) && !$rose(bank_reg.status[ST_EP0_RX]))
        else $error("paused engine reacted");

    read_clear_a: assert property (
        @(posedge mclk) disable iff (rst)
        stRdHit |=> (bank_reg.status & $past(bank_reg.status & ~setNow)) == STAT_RST)
        else $error("status bit not cleared by read");

    line_levels_a: assert property (
        @(posedge mclk) disable iff (rst)
        usbResetActive |=> bank_reg.status[ST_BUS_RESET])
        else $error("bus reset not flagged");

    suspend_flag_a: assert property (
        @(posedge mclk) disable iff (rst)
        suspendActive |=> bank_reg.status[ST_SUSPEND])
        else $error("suspend not flagged");

    detach_flag_a: assert property (
        @(posedge mclk) disable iff (rst)
        cableDetached |=> bank_reg.status[ST_DETACH])
        else $error("detach not flagged");

    ep0_rx_a: assert property (
        @(posedge mclk) disable iff (rst)
        ep0RxDone && engineRun |=> bank_reg.status[ST_EP0_RX])
        else $error("ep0 receive not flagged");

    sof_frame_a: assert property (
        @(posedge mclk) disable iff (rst)
        sofRx && engineRun |=>
            bank_reg.frame == $past(sofFrameNum) && bank_reg.status[ST_SOF])
        else $error("frame number not captured");

    master_gate_a: assert property (
        @(posedge mclk) disable iff (rst)
        !bank_reg.ie[STAT_W] |-> !interrupt)
        else $error("interrupt without master enable");

    irq_drop_a: assert property (
        @(posedge mclk) disable iff (rst)
        stRdHit && (setNow & bank_reg.ie[STAT_W-1:0]) == STAT_RST && !wrTake
            |=> !interrupt)
        else $error("interrupt held after status read");

    nak_ready_a: assert property (
        @(posedge mclk) disable iff (rst)
        txnValid && engineRun && txnEndpoint == 3'h0 && !bufReady[0]
            |=> nakValid && nakRequired)
        else $error("unready buffer not nakked");

    bus_ack_a: assert property (
        @(posedge mclk) disable iff (rst)
        busTakeS |=> ackPulseS)
        else $error("bus cycle not acked once");

endmodule : usbrb_register_bank

// File: usbrb_cpu_model.sv
// usbrb_cpu_model: processor bus master that drives the register bank
`timescale 1ns/1ps
module usbrb_cpu_model
    import usbrb_pkg::*;
(
    // clock
    input wire logic mclk,
    // memory bus towards the bank
    output logic [31:0] busAddr,
    output logic [3:0] busByteLaneSelects,
    output logic [31:0] busWrData,
    output logic busReadNotWrite,
    output logic busSelect,
    input wire logic [31:0] busRdData,
    input wire logic busXferAck
);
    initial begin
        busAddr = 32'h0000_0000;
        busByteLaneSelects = 4'h0;
        busWrData = 32'h0000_0000;
        busReadNotWrite = 1'b1;
        busSelect = 1'b0;
    end

    // ----------------------------------------
    // one bus cycle, entered just after an edge
    // ----------------------------------------
    // lanes vary but whole words are expected
    task automatic cycle(input logic [7:0] ofs, input logic rnw, input logic [31:0] wd,
        input logic [3:0] lanes, output logic [31:0] rd);
        int n;
        n = 0;
        busAddr <= {24'h00_0000, ofs};
        busReadNotWrite <= rnw;
        busWrData <= wd;
        busByteLaneSelects <= lanes;
        busSelect <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (busXferAck !== 1'b1 && n < 8);
        rd = (busXferAck === 1'b1) ? busRdData : 32'hxxxx_xxxx;
        // released lines carry garbage so stale values are never trusted
        busSelect <= 1'b0;
        busAddr <= ~busAddr;
        busWrData <= ~busWrData;
        busByteLaneSelects <= ~busByteLaneSelects;
        busReadNotWrite <= ~busReadNotWrite;
        @(posedge mclk);
    endtask : cycle
endmodule : usbrb_cpu_model

// File: usbrb_register_bank_tb.sv
// usbrb_register_bank_tb: self-checking bench for the register bank
`timescale 1ns/1ps
module usbrb_register_bank_tb
    import usbrb_pkg::*;
;
    logic mclk;
    logic rst;
    logic [31:0] busAddr;
    logic [3:0] busByteLaneSelects;
    logic [31:0] busWrData;
    logic busReadNotWrite;
    logic busSelect;
    logic [31:0] busRdData;
    logic busXferAck;
    logic usbResetActive = 1'b0, suspendActive = 1'b0, cableDetached = 1'b0, highSpeed = 1'b0;
    logic ep0RxDone = 1'b0, ep0TxDone = 1'b0, setupRx = 1'b0, sofRx = 1'b0;
    logic [FRAME_W-1:0] sofFrameNum = 11'h000;
    logic [BUF_W-1:0] bufComplete = 16'h0000;
    logic txnValid = 1'b0, txnSecondBuf = 1'b0, txnIsIn = 1'b0;
    logic [2:0] txnEndpoint = 3'h0;
    logic [EP_NUM-1:0] endpointDirectionFlag = 8'h00;
    logic [ADDR_W-1:0] deviceAddress;
    logic engineRun;
    logic [BUF_W-1:0] bufReady;
    logic nakValid;
    logic nakRequired;
    logic interrupt;
    int miscompares = 0;
    int checked = 0;

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    usbrb_register_bank #(.BUS_W(32)) dut (
        .mclk, .rst, .busAddr, .busByteLaneSelects, .busWrData, .busReadNotWrite,
        .busSelect, .busRdData, .busXferAck, .usbResetActive, .suspendActive,
        .cableDetached, .highSpeed, .ep0RxDone, .ep0TxDone, .setupRx, .sofRx,
        .sofFrameNum, .bufComplete, .txnValid, .txnEndpoint, .txnSecondBuf, .txnIsIn,
        .endpointDirectionFlag, .deviceAddress, .engineRun, .bufReady, .nakValid,
        .nakRequired, .interrupt
    );

    usbrb_cpu_model cpu (
        .mclk, .busAddr, .busByteLaneSelects, .busWrData, .busReadNotWrite,
        .busSelect, .busRdData, .busXferAck
    );

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [7:0] ofs, input logic [31:0] exp);
        logic [31:0] d;
        cpu.cycle(ofs, 1'b1, 32'h0000_0000, 4'hF, d);
        chk(d, exp);
    endtask : rd

    task automatic wr(input logic [7:0] ofs, input logic [31:0] wd, input logic [3:0] ln);
        logic [31:0] d;
        cpu.cycle(ofs, 1'b0, wd, ln, d);
        chk(d, 32'h0000_0000);
    endtask : wr

    task automatic ev(input logic [3:0] p, input logic [15:0] bc);
        {ep0RxDone, ep0TxDone, setupRx, sofRx} <= p;
        bufComplete <= bc;
        @(posedge mclk);
        {ep0RxDone, ep0TxDone, setupRx, sofRx} <= 4'h0;
        bufComplete <= 16'h0000;
        repeat (2) @(posedge mclk);
    endtask : ev

    task automatic irq(input logic e);
        chk({31'h0000_0000, interrupt}, {31'h0000_0000, e});
    endtask : irq

    // answer is sampled one edge after the take
    task automatic look(input logic [2:0] ep, input logic sb, input logic dirIn,
        input logic [1:0] e);
        txnValid <= 1'b1;
        txnEndpoint <= ep;
        txnSecondBuf <= sb;
        txnIsIn <= dirIn;
        @(posedge mclk);
        txnValid <= 1'b0;
        @(posedge mclk);
        chk({30'h0000_0000, nakValid, nakRequired}, {30'h0000_0000, e});
    endtask : look

    task automatic give_verdict();
        $display("compares %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        rst = 1'b1;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        chk({7'h00, deviceAddress, engineRun, bufReady, interrupt}, 32'h0000_0000);
        for (int i = 0; i < 7; i++) begin
            rd(8'(i * 4), 32'h0000_0000);
        end
        $display("test reset done");

        wr(OFS_ADDRESS, 32'h0000_007F, 4'h2);
        rd(OFS_ADDRESS, 32'h0000_007F);
        chk({25'h000_0000, deviceAddress}, 32'h0000_007F);
        $display("test address done");

        ev(4'h8, 16'h0000);
        rd(OFS_STATUS, 32'h0000_0000);
        look(3'h0, 1'b0, 1'b1, 2'b00);
        wr(OFS_CONTROL, 32'hFFFF_FFFF, 4'h0);
        rd(OFS_CONTROL, 32'h8000_0000);
        chk({31'h0000_0000, engineRun}, 32'h0000_0001);
        $display("test control done");

        sofFrameNum <= 11'h7FF;
        for (int i = 0; i < 4; i++) begin
            ev(4'h8 >> i, 16'h0000);
            rd(OFS_STATUS, 32'h0010_0000 >> i);
            rd(OFS_STATUS, 32'h0000_0000);
        end
        rd(OFS_FRAME, 32'h0000_3FF8);
        ev(4'h0, 16'hFFFF);
        rd(OFS_STATUS, 32'h0000_FEFF);
        for (int i = 0; i < 3; i++) begin
            {usbResetActive, suspendActive, cableDetached} <= 3'b100 >> i;
            @(posedge mclk);
            rd(OFS_STATUS, 32'h0080_0000 >> i);
            rd(OFS_STATUS, 32'h0080_0000 >> i);
            {usbResetActive, suspendActive, cableDetached} <= 3'b000;
            @(posedge mclk);
            rd(OFS_STATUS, 32'h0080_0000 >> i);
            rd(OFS_STATUS, 32'h0000_0000);
        end
        highSpeed <= 1'b1;
        ev(4'h1, 16'h0000);
        ev(4'h1, 16'h0000);
        rd(OFS_FRAME, 32'h0000_3FFA);
        sofFrameNum <= 11'h000;
        ev(4'h1, 16'h0000);
        rd(OFS_FRAME, 32'h0000_0000);
        rd(OFS_STATUS, 32'h0003_0000);
        rd(OFS_STATUS, 32'h0001_0000);
        highSpeed <= 1'b0;
        @(posedge mclk);
        rd(OFS_STATUS, 32'h0001_0000);
        rd(OFS_STATUS, 32'h0000_0000);
        $display("test status done");

        wr(OFS_IENABLE, 32'h0010_0000, 4'h1);
        ev(4'h8, 16'h0000);
        irq(1'b0);
        rd(OFS_STATUS, 32'h0010_0000);
        wr(OFS_IENABLE, 32'h8010_0000, 4'h8);
        rd(OFS_IENABLE, 32'h8010_0000);
        ev(4'h8, 16'h0000);
        irq(1'b1);
        rd(OFS_STATUS, 32'h0010_0000);
        irq(1'b0);
        wr(OFS_IENABLE, 32'h8080_0000, 4'hF);
        usbResetActive <= 1'b1;
        repeat (2) @(posedge mclk);
        irq(1'b1);
        rd(OFS_STATUS, 32'h0080_0000);
        irq(1'b1);
        wr(OFS_IENABLE, 32'h8000_0000, 4'hF);
        irq(1'b0);
        usbResetActive <= 1'b0;
        @(posedge mclk);
        rd(OFS_STATUS, 32'h0080_0000);
        $display("test interrupt done");

        look(3'h0, 1'b0, 1'b1, 2'b11);
        wr(OFS_READY, 32'hFFFF_FFFF, 4'h1);
        rd(OFS_READY, 32'h0000_FEFF);
        endpointDirectionFlag <= 8'hF0;
        look(3'h0, 1'b0, 1'b1, 2'b10);
        look(3'h0, 1'b0, 1'b0, 2'b10);
        look(3'h1, 1'b0, 1'b0, 2'b10);
        look(3'h1, 1'b0, 1'b1, 2'b11);
        look(3'h5, 1'b1, 1'b1, 2'b10);
        look(3'h5, 1'b1, 1'b0, 2'b11);
        wr(OFS_READY, 32'h0000_0001, 4'hF);
        chk({16'h0000, bufReady}, 32'h0000_0001);
        look(3'h1, 1'b0, 1'b0, 2'b11);
        look(3'h5, 1'b1, 1'b1, 2'b11);
        look(3'h0, 1'b0, 1'b1, 2'b10);
        // a completed buffer is retired until firmware rearms it
        ev(4'h0, 16'h0001);
        rd(OFS_STATUS, 32'h0000_0001);
        chk({16'h0000, bufReady}, 32'h0000_0000);
        $display("test nak done");
        give_verdict();
    end

    // hang guard, far beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        give_verdict();
    end
endmodule : usbrb_register_bank_tb
